// File: hdl/i2cp_defs.vh
// Constants shared by the I2C target front end with its control byte.
`ifndef I2CP_DEFS_VH
`define I2CP_DEFS_VH

// Upper three bits of the regular target address; the four low bits come from pins.
`define I2CP_REG_ADDR_HI 3'h6
// Reserved soft reset call address (seven bits) and its two key bytes.
`define I2CP_SOFT_ADDR 7'h6B
`define I2CP_SOFT_KEY1 8'hA5
`define I2CP_SOFT_KEY2 8'h5A

// Control byte layout.
`define I2CP_PTR_HI 4
`define I2CP_PTR_LO 0
`define I2CP_MODE_HI 7
`define I2CP_MODE_LO 5
`define I2CP_INC_EN_BIT 2
`define I2CP_CTRL_RESET 8'h00

// Increment modes.
`define I2CP_MODE_ALL 3'h4
`define I2CP_MODE_BRIGHT 3'h5
`define I2CP_MODE_GROUP 3'h6
`define I2CP_MODE_BOTH 3'h7

// Register pointer landmarks.
`define I2CP_PTR_FIRST 5'h00
`define I2CP_PTR_LAST 5'h1B
`define I2CP_BRIGHT_FIRST 5'h02
`define I2CP_BRIGHT_LAST 5'h11
`define I2CP_GROUP_FIRST 5'h12
`define I2CP_GROUP_LAST 5'h13
`define I2CP_PTR_STEP 5'h01

// Bit counting within a byte.
`define I2CP_BIT_ZERO 4'h0
`define I2CP_BIT_ONE 4'h1
`define I2CP_BIT_LAST 4'h7
`define I2CP_BITS_BYTE 4'h8

// Link state machine.
`define I2CP_ST_IDLE 3'h0
`define I2CP_ST_RX 3'h1
`define I2CP_ST_RX_ACK 3'h2
`define I2CP_ST_TX 3'h3
`define I2CP_ST_TX_ACK 3'h4
`define I2CP_ST_WAIT 3'h5

// Meaning of the byte being received.
`define I2CP_K_ADDR 3'h0
`define I2CP_K_CTRL 3'h1
`define I2CP_K_DATA 3'h2
`define I2CP_K_KEY1 3'h3
`define I2CP_K_KEY2 3'h4
`define I2CP_K_EXTRA 3'h5

`endif

// File: hdl/i2cp_target.v
// I2C target front end: bus conditions, byte exchange, control byte and pointer.
`timescale 1ns/1ps
`include "i2cp_defs.vh"

module i2cp_target
(
   input wire ref_clk,
   input wire rst_n,
   input wire scl_i,
   input wire sda_i,
   output wire sda_o,
   output wire sda_oe,
   input wire [3:0] addr_pins,
   input wire group_call_enable,
   input wire [6:0] group_call_address,
   input wire [2:0] sub_call_enable,
   input wire [6:0] sub_call_address1,
   input wire [6:0] sub_call_address2,
   input wire [6:0] sub_call_address3,
   output wire [7:0] register_pointer_control,
   output wire [4:0] reg_addr,
   output wire [7:0] reg_wdata,
   output wire reg_wr,
   output wire reg_rd,
   input wire [7:0] reg_rdata,
   output wire soft_reset,
   output wire bus_busy
);

   // Pointer after one access in the given increment mode.
   function [4:0] next_ptr;
      input [4:0] p;
      input [2:0] m;
      begin
         if (!m[`I2CP_INC_EN_BIT])
            next_ptr = p;
         else if (p >= `I2CP_PTR_LAST)
            next_ptr = `I2CP_PTR_FIRST;
         else
            case (m)
               `I2CP_MODE_BRIGHT:
                  next_ptr = (p == `I2CP_BRIGHT_LAST) ? `I2CP_BRIGHT_FIRST :
                     p + `I2CP_PTR_STEP;
               `I2CP_MODE_GROUP:
                  next_ptr = (p == `I2CP_GROUP_LAST) ? `I2CP_GROUP_FIRST :
                     p + `I2CP_PTR_STEP;
               `I2CP_MODE_BOTH:
                  next_ptr = (p == `I2CP_GROUP_LAST) ? `I2CP_BRIGHT_FIRST :
                     p + `I2CP_PTR_STEP;
               default:
                  next_ptr = p + `I2CP_PTR_STEP;
            endcase
      end
   endfunction

   reg rst_s1_q;
   reg rst_s2_q;

   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end
      else
      begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end

   wire rst_int_n = rst_s2_q;

   // Bus lines and pins pass two flops; the third stage only serves edge detection.
   reg scl_s1_q;
   reg scl_s2_q;
   reg scl_s3_q;
   reg sda_s1_q;
   reg sda_s2_q;
   reg sda_s3_q;
   reg [3:0] pins_s1_q;
   reg [3:0] pins_s2_q;

   always @(posedge ref_clk or negedge rst_int_n)
   begin
      if (!rst_int_n)
      begin
         scl_s1_q <= 1'b1;
         scl_s2_q <= 1'b1;
         scl_s3_q <= 1'b1;
         sda_s1_q <= 1'b1;
         sda_s2_q <= 1'b1;
         sda_s3_q <= 1'b1;
         pins_s1_q <= 4'h0;
         pins_s2_q <= 4'h0;
      end
      else
      begin
         scl_s1_q <= scl_i;
         scl_s2_q <= scl_s1_q;
         scl_s3_q <= scl_s2_q;
         sda_s1_q <= sda_i;
         sda_s2_q <= sda_s1_q;
         sda_s3_q <= sda_s2_q;
         pins_s1_q <= addr_pins;
         pins_s2_q <= pins_s1_q;
      end
   end

   wire scl_rise = scl_s2_q & ~scl_s3_q;
   wire scl_fall = ~scl_s2_q & scl_s3_q;
   // Both lines move through equal delay, so SDA edges are judged against settled SCL.
   wire start_cond = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
   wire stop_cond = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;

   reg [2:0] state_q;
   reg [2:0] kind_q;
   reg [3:0] cnt_q;
   reg [7:0] sh_q;
   reg ack_q;
   reg armed_q;
   reg [7:0] ctrl_q;
   reg oe_q;
   reg out_q;
   reg wr_q;
   reg rd_q;
   reg [7:0] wdata_q;
   reg srst_q;
   reg busy_q;

   wire [6:0] rx_addr = sh_q[7:1];
   wire rx_read = sh_q[0];
   wire [4:0] ptr = ctrl_q[`I2CP_PTR_HI:`I2CP_PTR_LO];
   wire [2:0] mode = ctrl_q[`I2CP_MODE_HI:`I2CP_MODE_LO];
   wire [6:0] own_addr = {`I2CP_REG_ADDR_HI, pins_s2_q};
   wire hit_soft = (rx_addr == `I2CP_SOFT_ADDR);
   wire hit_own = (rx_addr == own_addr) |
      (group_call_enable & (rx_addr == group_call_address)) |
      (sub_call_enable[0] & (rx_addr == sub_call_address1)) |
      (sub_call_enable[1] & (rx_addr == sub_call_address2)) |
      (sub_call_enable[2] & (rx_addr == sub_call_address3));

   always @(posedge ref_clk or negedge rst_int_n)
   begin
      if (!rst_int_n)
      begin
         state_q <= `I2CP_ST_IDLE;
         kind_q <= `I2CP_K_ADDR;
         cnt_q <= `I2CP_BIT_ZERO;
         sh_q <= 8'h00;
         ack_q <= 1'b0;
         armed_q <= 1'b0;
         ctrl_q <= `I2CP_CTRL_RESET;
         oe_q <= 1'b0;
         out_q <= 1'b0;
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         wdata_q <= 8'h00;
         srst_q <= 1'b0;
         busy_q <= 1'b0;
      end
      else
      begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         srst_q <= 1'b0;
         if (stop_cond)
         begin
            state_q <= `I2CP_ST_IDLE;
            oe_q <= 1'b0;
            busy_q <= 1'b0;
            armed_q <= 1'b0;
            if (armed_q)
            begin
               srst_q <= 1'b1;
               ctrl_q <= `I2CP_CTRL_RESET;
            end
         end
         else if (start_cond)
         begin
            // A repeated START is taken as well; an unfinished soft reset is dropped.
            state_q <= `I2CP_ST_RX;
            kind_q <= `I2CP_K_ADDR;
            cnt_q <= `I2CP_BIT_ZERO;
            oe_q <= 1'b0;
            busy_q <= 1'b1;
            armed_q <= 1'b0;
         end
         else
         begin
            case (state_q)
               `I2CP_ST_RX:
               begin
                  if (scl_rise && cnt_q != `I2CP_BITS_BYTE)
                  begin
                     sh_q <= {sh_q[6:0], sda_s2_q};
                     cnt_q <= cnt_q + `I2CP_BIT_ONE;
                  end
                  else if (scl_fall && cnt_q == `I2CP_BITS_BYTE)
                  begin
                     state_q <= `I2CP_ST_RX_ACK;
                     ack_q <= 1'b0;
                     case (kind_q)
                        `I2CP_K_ADDR:
                        begin
                           if (hit_soft)
                           begin
                              ack_q <= ~rx_read;
                              oe_q <= ~rx_read;
                              kind_q <= `I2CP_K_KEY1;
                           end
                           else if (hit_own)
                           begin
                              ack_q <= 1'b1;
                              oe_q <= 1'b1;
                              kind_q <= rx_read ? `I2CP_K_ADDR : `I2CP_K_CTRL;
                           end
                        end
                        `I2CP_K_CTRL:
                        begin
                           ctrl_q <= sh_q;
                           ack_q <= 1'b1;
                           oe_q <= 1'b1;
                           kind_q <= `I2CP_K_DATA;
                        end
                        `I2CP_K_DATA:
                        begin
                           wr_q <= 1'b1;
                           wdata_q <= sh_q;
                           ctrl_q[`I2CP_PTR_HI:`I2CP_PTR_LO] <= next_ptr(ptr, mode);
                           ack_q <= 1'b1;
                           oe_q <= 1'b1;
                        end
                        `I2CP_K_KEY1:
                        begin
                           ack_q <= (sh_q == `I2CP_SOFT_KEY1);
                           oe_q <= (sh_q == `I2CP_SOFT_KEY1);
                           kind_q <= `I2CP_K_KEY2;
                        end
                        `I2CP_K_KEY2:
                        begin
                           ack_q <= (sh_q == `I2CP_SOFT_KEY2);
                           oe_q <= (sh_q == `I2CP_SOFT_KEY2);
                           armed_q <= (sh_q == `I2CP_SOFT_KEY2);
                           kind_q <= `I2CP_K_EXTRA;
                        end
                        default:
                           // Any byte beyond the two keys aborts the soft reset.
                           armed_q <= 1'b0;
                     endcase
                  end
               end
               `I2CP_ST_RX_ACK:
               begin
                  if (scl_fall)
                  begin
                     cnt_q <= `I2CP_BIT_ZERO;
                     if (!ack_q)
                     begin
                        state_q <= `I2CP_ST_WAIT;
                        oe_q <= 1'b0;
                     end
                     else if (kind_q == `I2CP_K_ADDR)
                     begin
                        state_q <= `I2CP_ST_TX;
                        sh_q <= reg_rdata;
                        rd_q <= 1'b1;
                        oe_q <= ~reg_rdata[7];
                     end
                     else
                     begin
                        state_q <= `I2CP_ST_RX;
                        oe_q <= 1'b0;
                     end
                  end
               end
               `I2CP_ST_TX:
               begin
                  if (scl_fall)
                  begin
                     if (cnt_q == `I2CP_BIT_LAST)
                     begin
                        state_q <= `I2CP_ST_TX_ACK;
                        oe_q <= 1'b0;
                     end
                     else
                     begin
                        sh_q <= {sh_q[6:0], 1'b0};
                        oe_q <= ~sh_q[6];
                        cnt_q <= cnt_q + `I2CP_BIT_ONE;
                     end
                  end
               end
               `I2CP_ST_TX_ACK:
               begin
                  if (scl_rise)
                  begin
                     ack_q <= ~sda_s2_q;
                     ctrl_q[`I2CP_PTR_HI:`I2CP_PTR_LO] <= next_ptr(ptr, mode);
                  end
                  else if (scl_fall)
                  begin
                     cnt_q <= `I2CP_BIT_ZERO;
                     if (ack_q)
                     begin
                        state_q <= `I2CP_ST_TX;
                        sh_q <= reg_rdata;
                        rd_q <= 1'b1;
                        oe_q <= ~reg_rdata[7];
                     end
                     else
                     begin
                        state_q <= `I2CP_ST_WAIT;
                        oe_q <= 1'b0;
                     end
                  end
               end
               `I2CP_ST_WAIT:
                  oe_q <= 1'b0;
               default:
               begin
                  state_q <= `I2CP_ST_IDLE;
                  oe_q <= 1'b0;
               end
            endcase
         end
      end
   end

   // The pad only ever pulls low; the line rises through the bus pull-up.
   assign sda_o = out_q;
   assign sda_oe = oe_q;
   assign register_pointer_control = ctrl_q;
   assign reg_addr = ctrl_q[`I2CP_PTR_HI:`I2CP_PTR_LO];
   assign reg_wdata = wdata_q;
   assign reg_wr = wr_q;
   assign reg_rd = rd_q;
   assign soft_reset = srst_q;
   assign bus_busy = busy_q;

endmodule

// File: dv/i2cp_target_properties.sv
// Concurrent checks on the ports of the I2C target front end.
`timescale 1ns/1ps
module i2cp_target_props
(
   input wire ref_clk,
   input wire rst_n,
   input wire scl_i,
   input wire sda_oe,
   input wire [7:0] register_pointer_control,
   input wire [4:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire soft_reset,
   input wire bus_busy
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   function automatic [4:0] nx(input [4:0] p, input [2:0] md);
   begin
      nx = p + 5'h01;
      if (!md[2])
         nx = p;
      else if (p >= 5'h1B)
         nx = 5'h00;
      else if ((md == 3'h5 && p == 5'h11) || (md[1] && p == 5'h13))
         nx = md[0] ? 5'h02 : 5'h12;
   end
   endfunction
   ptr_reset_a: assert property ($rose(rst_n) |-> register_pointer_control == 8'h00)
      else $error("control byte not clear after reset");
   ptr_addr_a: assert property (reg_addr == register_pointer_control[4:0])
      else $error("register address differs from pointer");
   ptr_step_a: assert property (reg_wr |->
      reg_addr == nx($past(reg_addr), register_pointer_control[7:5]))
      else $error("pointer stepped to a wrong register");
   mode_keep_a: assert property (reg_wr |-> $stable(register_pointer_control[7:5]))
      else $error("increment mode changed by a write");
   wr_pulse_a: assert property (reg_wr |=> !reg_wr)
      else $error("write strobe longer than one cycle");
   wr_busy_a: assert property (reg_wr |-> bus_busy)
      else $error("register write outside a transfer");
   idle_release_a: assert property (!bus_busy |-> !sda_oe)
      else $error("data line pulled while bus idle");
   sda_hold_a: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe))
      else $error("data drive changed while clock high");
   soft_clear_a: assert property (soft_reset |-> register_pointer_control == 8'h00 && !bus_busy)
      else $error("soft reset left control byte set");
   rd_pulse_a: assert property (reg_rd |=> !reg_rd)
      else $error("read strobe longer than one cycle");
   rd_busy_a: assert property (reg_rd |-> bus_busy)
      else $error("register read outside a transfer");
endmodule

bind i2cp_target i2cp_target_props chk_i (.ref_clk, .rst_n, .scl_i, .sda_oe,
   .register_pointer_control, .reg_addr, .reg_wr, .reg_rd, .soft_reset, .bus_busy);

// File: dv/i2cp_master_model.sv
// Behavioural I2C bus master that drives the link for the bench.
`timescale 1ns/1ps
module i2cp_master_model
(
   input wire ref_clk,
   input wire sda,
   output reg scl,
   output reg sda_low
);
   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // Half of the 160 ns link period, moved only on falling clock edges.
   task half;
      repeat (8) @(negedge ref_clk);
   endtask
   task start;
   begin
      sda_low = 1'b0;
      half;
      scl = 1'b1;
      half;
      sda_low = 1'b1;
      half;
      scl = 1'b0;
      half;
   end
   endtask
   task stop;
   begin
      sda_low = 1'b1;
      half;
      scl = 1'b1;
      half;
      sda_low = 1'b0;
      half;
   end
   endtask
   // Data moves two cycles after the clock falls so no edge looks like a bus condition.
   task send_bit(input b, output r);
   begin
      sda_low = !b;
      half;
      scl = 1'b1;
      half;
      r = sda;
      scl = 1'b0;
      repeat (2) @(negedge ref_clk);
   end
   endtask
   task wbyte(input [7:0] d, output ack);
      integer i;
      reg r;
   begin
      for (i = 7; i >= 0; i = i - 1)
         send_bit(d[i], r);
      send_bit(1'b1, r);
      ack = !r;
   end
   endtask
   task rbyte(input last, output [7:0] d);
      integer i;
      reg r;
   begin
      for (i = 0; i < 8; i = i + 1)
      begin
         send_bit(1'b1, r);
         d = {d[6:0], r};
      end
      send_bit(last, r);
   end
   endtask
endmodule

// File: dv/i2cp_tb.sv
// Self-checking bench for the I2C target front end.
`timescale 1ns/1ps
module tb;
   reg ref_clk = 1'b0;
   reg rst_n = 1'b0;
   reg gen = 1'b1;
   reg [3:0] pins = 4'h2;
   reg [7:0] rnd = 8'h45;
   reg [4:0] prev = 5'h00;
   reg [47:0] ctab = 48'h059AB0D2F3F4;
   reg [15:0] q[$];
   reg a;
   reg [7:0] d;
   integer error_cnt = 0;
   integer check_count = 0;
   integer sr = 0;
   integer rd_n = 0;
   integer k;
   wire scl;
   wire mlow;
   wire sda_oe;
   wire sda_o;
   // The pad pulls low only while enabled and driving zero; the pull-up does the rest.
   wire sda = !((sda_oe & !sda_o) | mlow);
   wire [7:0] ctl;
   wire [4:0] reg_addr;
   wire [7:0] reg_wdata;
   wire reg_wr;
   wire reg_rd;
   wire soft_reset;
   wire bus_busy;
   always #5 ref_clk = !ref_clk;
   i2cp_master_model m (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_low(mlow));
   i2cp_target uut (.ref_clk(ref_clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe(sda_oe), .addr_pins(pins), .group_call_enable(gen),
      .group_call_address(7'h68), .sub_call_enable(3'h1), .sub_call_address1(7'h69),
      .sub_call_address2(7'h6A), .sub_call_address3(7'h6C), .register_pointer_control(ctl),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata({3'h7, reg_addr}), .soft_reset(soft_reset), .bus_busy(bus_busy));
   function [7:0] lfsr(input [7:0] s);
      lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function [4:0] nx(input [4:0] p, input [2:0] md);
   begin
      nx = p + 5'h01;
      if (!md[2])
         nx = p;
      else if (p >= 5'h1B)
         nx = 5'h00;
      else if ((md == 3'h5 && p == 5'h11) || (md[1] && p == 5'h13))
         nx = md[0] ? 5'h02 : 5'h12;
   end
   endfunction
   task chk(input [15:0] g, input [15:0] e);
   begin
      check_count = check_count + 1;
      if (g !== e)
      begin
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
         error_cnt = error_cnt + 1;
      end
   end
   endtask
   task wa(input [7:0] b, input e);
   begin
      m.wbyte(b, a);
      chk({15'h0, a}, {15'h0, e});
   end
   endtask
   // Write twelve random bytes, then read four back after a repeated start.
   task xfer(input [7:0] c);
      reg [4:0] p;
      integer i;
   begin
      p = c[4:0];
      m.start;
      wa({3'h6, pins, 1'h0}, 1'h1);
      wa(c, 1'h1);
      for (i = 0; i < 12; i = i + 1)
      begin
         rnd = lfsr(rnd);
         q.push_back({3'h0, p, rnd});
         wa(rnd, 1'h1);
         p = nx(p, c[7:5]);
      end
      chk({8'h0, ctl}, {8'h0, c[7:5], p});
      m.start;
      wa({3'h6, pins, 1'h1}, 1'h1);
      for (i = 0; i < 4; i = i + 1)
      begin
         m.rbyte(i == 3, d);
         chk({8'h0, d}, {8'h0, 3'h7, p});
         p = nx(p, c[7:5]);
      end
      m.stop;
      chk({8'h0, ctl}, {8'h0, c[7:5], p});
   end
   endtask
   task finish_test;
   begin
      $display("errors %0d checks %0d", error_cnt, check_count);
      if (error_cnt == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   end
   endtask
   // Write results are matched against the oldest note as the strobe appears.
   always @(posedge ref_clk)
   begin
      if (reg_wr)
         chk(q.size() ? q.pop_front() : 16'hFFFF, {3'h0, prev, reg_wdata});
      if (soft_reset)
         sr = sr + 1;
      if (reg_rd)
         rd_n = rd_n + 1;
      prev = reg_addr;
   end
   initial
   begin
      repeat (100000) @(posedge ref_clk);
      error_cnt = error_cnt + 1;
      finish_test;
   end
   initial
   begin
      repeat (4) @(negedge ref_clk);
      rst_n = 1'b1;
      repeat (10) @(negedge ref_clk);
      chk({8'h0, ctl}, 16'h0000);
      for (k = 0; k < 6; k = k + 1)
         xfer(ctab[8*k +: 8]);
      m.start;
      wa(8'hD7, 1'h0);
      m.start;
      wa(8'hD6, 1'h1);
      wa(8'hA4, 1'h0);
      m.stop;
      chk(sr[15:0], 16'h0000);
      m.start;
      wa(8'hD6, 1'h1);
      wa(8'hA5, 1'h1);
      wa(8'h5A, 1'h1);
      m.stop;
      repeat (8) @(negedge ref_clk);
      chk(sr[15:0], 16'h0001);
      chk({8'h0, ctl}, 16'h0000);
      m.start;
      wa({3'h6, ~pins, 1'h0}, 1'h0);
      m.start;
      wa(8'hD2, 1'h1);
      wa(8'h83, 1'h1);
      chk({8'h0, ctl}, 16'h0083);
      m.start;
      wa(8'hD1, 1'h1);
      m.rbyte(1'b1, d);
      chk({8'h0, d}, 16'h00E3);
      m.stop;
      chk({8'h0, ctl}, 16'h0084);
      // A pin reset in mid-run must clear the control byte as well.
      rst_n = 1'b0;
      repeat (4) @(negedge ref_clk);
      rst_n = 1'b1;
      repeat (4) @(negedge ref_clk);
      chk({8'h0, ctl}, 16'h0000);
      gen = 1'b0;
      m.start;
      wa(8'hD0, 1'h0);
      m.stop;
      chk(rd_n[15:0], 16'h0019);
      chk(16'(q.size()), 16'h0000);
      finish_test;
   end
endmodule
